/* File: logic/lfrc_pkg.sv */
// Purpose: shared constants for link fault and receive control
// Assumes: 32-bit ahb-lite register access, word aligned
// Notes:   all offsets are byte addresses
package lfrc_pkg;
    localparam int LANES = 20;
    localparam int ERR_W = 2;
    // code word selector driven toward the pcs encoder
    typedef enum logic [1:0] {
        LFRC_TX_DATA  = 2'h0,
        LFRC_TX_IDLE  = 2'h1,
        LFRC_TX_RFI   = 2'h3,
        LFRC_TX_LFI   = 2'h2
    } lfrc_txsel_t;
    // receive control state, gray along init -> run -> drain -> off
    typedef enum logic [1:0] {
        LFRC_RX_INIT  = 2'h0,
        LFRC_RX_RUN   = 2'h1,
        LFRC_RX_DRAIN = 2'h3,
        LFRC_RX_OFF   = 2'h2
    } lfrc_rxst_t;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ    = 8'h08;
    localparam logic [7:0] OFF_MASK   = 8'h0C;
    // control register fields
    localparam int CTRL_TX_EN     = 0;
    localparam int CTRL_SEND_LFI  = 1;
    localparam int CTRL_SEND_RFI  = 2;
    localparam int CTRL_SEND_IDLE = 3;
    localparam int CTRL_RX_EN     = 4;
    localparam int CTRL_RESYNC    = 5;
    localparam logic [5:0] CTRL_RESET = 6'h16;
    // irq/mask fields
    localparam int IRQ_LOCAL_FAULT = 0;
    localparam int IRQ_FRAMING     = 1;
    localparam int IRQ_RX_STOPPED  = 2;
    localparam int IRQ_W           = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [2:0] IRQ_RESET  = 3'h0;
    // status register fields
    localparam int STAT_LOCAL_FAULT = 0;
    localparam int STAT_TX_STOPPED  = 1;
    localparam int STAT_RX_STATE    = 2;
    localparam int STAT_DECODE      = 4;
    localparam int STAT_ALIGNED     = 5;
    localparam int STAT_W           = 6;
    localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;
    // cycles spent re-aligning after a resync before the rx runs
    localparam int ALIGN_CYCLES = 16;
endpackage

/* File: logic/lfrc_top.sv */
// Purpose: transmit fault forcing and receive path control of a 100g mac
// Assumes: one 50 MHz clock, synchronous active-high reset, ahb-lite slave
// Notes:   pcs-facing signals are plain per-lane ports, no buffering
//
// Functional notes
// - rfi force sends only remote fault words; here lfi force wins over it
// - idle force sends only idle words; here lfi and rfi forces win over it
// - local fault status high in rx init
// - rx disable finishes packet, then stops decoding
// - rx disabled: no statistics, user bus idle
// - resync high resets rx, realigns it
// - per lane 2-bit sync header error count
// - error count valid only with qualifier
// - counts change any cycle, used as increments
// - lfi force sends only local fault words
// - tx disable finishes packet, then only idles; here lfi and rfi forces still win over the idles
`timescale 1ns/1ps
module lfrc_top #(
    parameter int LANES        = lfrc_pkg::LANES,
    parameter int ALIGN_CYCLES = lfrc_pkg::ALIGN_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic                        irq,
    input  wire logic                   tx_pkt_active,
    output logic      [1:0]             tx_code_sel,
    input  wire logic                   rx_pkt_active,
    input  wire logic                   rx_lanes_aligned,
    input  wire logic [LANES*2-1:0]     lane_hdr_err,
    input  wire logic                   seg_valid_in,
    output logic                        pcs_decode_en,
    output logic                        rx_path_reset,
    output logic                        user_segment_bus_valid,
    output logic                        stat_en,
    output logic                        tx_local_fault,
    output logic      [LANES*2-1:0]     framing_err,
    output logic      [LANES-1:0]       framing_err_valid
);
    localparam int               ERR_W    = lfrc_pkg::ERR_W;
    localparam int               STAT_W   = lfrc_pkg::STAT_W;
    localparam int               IRQ_W    = lfrc_pkg::IRQ_W;
    localparam int               CNT_W    = $clog2(ALIGN_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ALIGN_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    // bus side
    logic                       ap_valid;
    logic                       ap_read;
    logic                       ap_write;
    logic                       dp_wr;
    logic [7:0]                 dp_addr;
    logic                       wr_ctrl;
    logic                       wr_irq;
    logic                       wr_mask;
    logic [31:0]                rd_word;

    // software visible state
    logic [5:0]                 ctrl;
    logic [5:0]                 next_ctrl;
    logic [IRQ_W-1:0]           irq_stat;
    logic [IRQ_W-1:0]           next_irq_stat;
    logic [IRQ_W-1:0]           irq_mask;
    logic [IRQ_W-1:0]           next_irq_mask;
    logic [IRQ_W-1:0]           irq_event;
    logic [IRQ_W-1:0]           irq_clear;
    logic                       next_irq;
    logic [STAT_W-1:0]          status_word;

    // control fields
    logic                       tx_en_bit;
    logic                       send_lfi_bit;
    logic                       send_rfi_bit;
    logic                       send_idle_bit;
    logic                       rx_en_bit;
    logic                       resync_req;

    // transmit side
    logic                       tx_stopped;
    logic                       next_tx_stopped;
    lfrc_pkg::lfrc_txsel_t      next_tx_sel;

    // receive side
    lfrc_pkg::lfrc_rxst_t       rx_state;
    lfrc_pkg::lfrc_rxst_t       next_rx_state;
    logic [CNT_W-1:0]           align_cnt;
    logic [CNT_W-1:0]           next_align_cnt;
    logic                       align_done;
    logic                       rx_busy;
    logic                       lane_lost;
    logic                       restart;
    logic                       decode_next;
    logic                       init_next;
    logic                       resetting_next;
    logic                       enter_init;
    logic                       enter_off;
    logic                       any_lane_err;
    logic [LANES-1:0]           lane_err_any;
    logic [LANES*ERR_W-1:0]     next_framing_err;
    logic [LANES-1:0]           next_framing_err_valid;

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------------
    // only the low address byte is decoded, so registers alias upward;
    // hsize is not checked because only whole words are defined
    assign ap_valid = hsel && htrans[1] && hready;
    assign ap_read  = ap_valid && !hwrite;
    assign ap_write = ap_valid && hwrite;
    assign wr_ctrl  = dp_wr && (dp_addr == lfrc_pkg::OFF_CTRL);
    assign wr_irq   = dp_wr && (dp_addr == lfrc_pkg::OFF_IRQ);
    assign wr_mask  = dp_wr && (dp_addr == lfrc_pkg::OFF_MASK);

    always_ff @(posedge clk) begin
        if (rst) begin
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr   <= ap_write;
            dp_addr <= haddr[7:0];
        end
    end

    // read data is latched in the address phase: a read issued in the
    // data phase of a write to the same register sees the old value
    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[7:0] == lfrc_pkg::OFF_CTRL) begin
            rd_word = 32'(ctrl);
        end else if (haddr[7:0] == lfrc_pkg::OFF_STATUS) begin
            rd_word = 32'(status_word);
        end else if (haddr[7:0] == lfrc_pkg::OFF_IRQ) begin
            rd_word = 32'(irq_stat);
        end else if (haddr[7:0] == lfrc_pkg::OFF_MASK) begin
            rd_word = 32'(irq_mask);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= lfrc_pkg::HRDATA_RESET;
        end else if (ap_read) begin
            hrdata <= rd_word;
        end
    end

    // no wait states and no errors; kept as flops so every output is registered
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // resync is a write strobe only, never stored, so it reads back 0
    assign next_ctrl     = wr_ctrl ? {1'b0, hwdata[lfrc_pkg::CTRL_RX_EN:0]} : ctrl;
    assign resync_req    = wr_ctrl && hwdata[lfrc_pkg::CTRL_RESYNC];
    assign tx_en_bit     = ctrl[lfrc_pkg::CTRL_TX_EN];
    assign send_lfi_bit  = ctrl[lfrc_pkg::CTRL_SEND_LFI];
    assign send_rfi_bit  = ctrl[lfrc_pkg::CTRL_SEND_RFI];
    assign send_idle_bit = ctrl[lfrc_pkg::CTRL_SEND_IDLE];
    assign rx_en_bit     = ctrl[lfrc_pkg::CTRL_RX_EN];

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= lfrc_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign status_word[lfrc_pkg::STAT_LOCAL_FAULT]    = tx_local_fault;
    assign status_word[lfrc_pkg::STAT_TX_STOPPED]     = tx_stopped;
    assign status_word[lfrc_pkg::STAT_RX_STATE +: 2]  = rx_state;
    assign status_word[lfrc_pkg::STAT_DECODE]         = pcs_decode_en;
    assign status_word[lfrc_pkg::STAT_ALIGNED]        = rx_lanes_aligned;

    // ------------------------------------------------------------------
    // transmit code selection
    // ------------------------------------------------------------------
    // enable changes only between packets, so disabling never cuts a packet
    assign next_tx_stopped = tx_pkt_active ? tx_stopped : !tx_en_bit;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_stopped <= !lfrc_pkg::CTRL_RESET[lfrc_pkg::CTRL_TX_EN];
        end else begin
            tx_stopped <= next_tx_stopped;
        end
    end

    // forces act at once, even inside a packet: a fault overrides framing
    always_comb begin
        if (send_lfi_bit) begin
            next_tx_sel = lfrc_pkg::LFRC_TX_LFI;
        end else if (send_rfi_bit) begin
            next_tx_sel = lfrc_pkg::LFRC_TX_RFI;
        end else if (send_idle_bit) begin
            next_tx_sel = lfrc_pkg::LFRC_TX_IDLE;
        end else if (tx_stopped) begin
            next_tx_sel = lfrc_pkg::LFRC_TX_IDLE;
        end else begin
            next_tx_sel = lfrc_pkg::LFRC_TX_DATA;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_code_sel <= lfrc_pkg::LFRC_TX_LFI;
        end else begin
            tx_code_sel <= next_tx_sel;
        end
    end

    // ------------------------------------------------------------------
    // receive control
    // ------------------------------------------------------------------
    assign align_done = (align_cnt == CNT_ZERO);
    assign rx_busy    = (rx_state == lfrc_pkg::LFRC_RX_RUN) ||
                        (rx_state == lfrc_pkg::LFRC_RX_DRAIN);
    assign lane_lost  = rx_busy && !rx_lanes_aligned;
    assign restart    = resync_req || lane_lost;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            lfrc_pkg::LFRC_RX_INIT: begin
                if (align_done && rx_lanes_aligned) begin
                    next_rx_state = rx_en_bit ? lfrc_pkg::LFRC_RX_RUN : lfrc_pkg::LFRC_RX_OFF;
                end
            end
            lfrc_pkg::LFRC_RX_RUN: begin
                if (!rx_en_bit) begin
                    next_rx_state = rx_pkt_active ? lfrc_pkg::LFRC_RX_DRAIN
                                                  : lfrc_pkg::LFRC_RX_OFF;
                end
            end
            lfrc_pkg::LFRC_RX_DRAIN: begin
                if (!rx_pkt_active) begin
                    next_rx_state = lfrc_pkg::LFRC_RX_OFF;
                end
            end
            lfrc_pkg::LFRC_RX_OFF: begin
                // resume only in a gap so leaving off never starts decoding mid-packet
                if (rx_en_bit && !rx_pkt_active) begin
                    next_rx_state = rx_lanes_aligned ? lfrc_pkg::LFRC_RX_RUN
                                                     : lfrc_pkg::LFRC_RX_INIT;
                end
            end
            default: begin
                next_rx_state = lfrc_pkg::LFRC_RX_INIT;
            end
        endcase
        if (restart) begin
            next_rx_state = lfrc_pkg::LFRC_RX_INIT;
        end
    end

    always_comb begin
        next_align_cnt = align_cnt;
        if (restart) begin
            next_align_cnt = CNT_LOAD;
        end else if (!align_done) begin
            next_align_cnt = align_cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state  <= lfrc_pkg::LFRC_RX_INIT;
            align_cnt <= CNT_LOAD;
        end else begin
            rx_state  <= next_rx_state;
            align_cnt <= next_align_cnt;
        end
    end

    // outputs follow the next state so they match the state register exactly
    assign decode_next    = (next_rx_state == lfrc_pkg::LFRC_RX_RUN) ||
                            (next_rx_state == lfrc_pkg::LFRC_RX_DRAIN);
    assign init_next      = (next_rx_state == lfrc_pkg::LFRC_RX_INIT);
    assign resetting_next = (next_align_cnt != CNT_ZERO);

    always_ff @(posedge clk) begin
        if (rst) begin
            pcs_decode_en          <= 1'b0;
            stat_en                <= 1'b0;
            user_segment_bus_valid <= 1'b0;
            tx_local_fault         <= 1'b1;
            rx_path_reset          <= 1'b1;
        end else begin
            pcs_decode_en          <= decode_next;
            stat_en                <= decode_next;
            user_segment_bus_valid <= seg_valid_in && decode_next;
            tx_local_fault         <= init_next;
            rx_path_reset          <= resetting_next;
        end
    end

    // ------------------------------------------------------------------
    // per lane sync header error increments
    // ------------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign lane_err_any[g] = |lane_hdr_err[g*ERR_W +: ERR_W];
        assign next_framing_err[g*ERR_W +: ERR_W] =
            decode_next ? lane_hdr_err[g*ERR_W +: ERR_W] : {ERR_W{1'b0}};
        assign next_framing_err_valid[g] = decode_next;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            framing_err       <= '0;
            framing_err_valid <= '0;
        end else begin
            framing_err       <= next_framing_err;
            framing_err_valid <= next_framing_err_valid;
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    assign enter_init   = init_next && (rx_state != lfrc_pkg::LFRC_RX_INIT);
    assign enter_off    = (next_rx_state == lfrc_pkg::LFRC_RX_OFF) &&
                          (rx_state != lfrc_pkg::LFRC_RX_OFF);
    assign any_lane_err = pcs_decode_en && (|lane_err_any);

    assign irq_event[lfrc_pkg::IRQ_LOCAL_FAULT] = enter_init;
    assign irq_event[lfrc_pkg::IRQ_FRAMING]     = any_lane_err;
    assign irq_event[lfrc_pkg::IRQ_RX_STOPPED]  = enter_off;

    // a new event in the clearing cycle wins, so no event is lost
    assign irq_clear     = wr_irq ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
    assign next_irq_stat = irq_event | (irq_stat & ~irq_clear);
    assign next_irq_mask = wr_mask ? hwdata[IRQ_W-1:0] : irq_mask;
    assign next_irq      = |(next_irq_stat & next_irq_mask);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat <= lfrc_pkg::IRQ_RESET;
            irq_mask <= lfrc_pkg::MASK_RESET;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq      <= next_irq;
        end
    end

endmodule

/* File: sim/lfrc_checker.sv */
// Purpose: port checks of lfrc_top
// Assumes: one clock, rst synchronous
// Notes: no fixed latency known, so checks stay relational
`timescale 1ns/1ps
module lfrc_checker #(
    parameter int LANES = 20
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             hresp,
    input wire logic             hreadyout,
    input wire logic             rx_pkt_active,
    input wire logic             pcs_decode_en,
    input wire logic             rx_path_reset,
    input wire logic             user_segment_bus_valid,
    input wire logic             stat_en,
    input wire logic             tx_local_fault,
    input wire logic [LANES-1:0] framing_err_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence rx_off;
        !pcs_decode_en;
    endsequence
    sequence reset_held;
        rx_path_reset [*8];
    endsequence
    resp_okay_a: assert property (!hresp) else $error("resp");
    ready_back_a: assert property (!hreadyout |-> ##[1:8] hreadyout) else $error("stall");
    bus_idle_a: assert property (rx_off |-> !user_segment_bus_valid) else $error("bus");
    stat_off_a: assert property (rx_off |-> !stat_en) else $error("stat");
    err_quiet_a: assert property (rx_off |-> !framing_err_valid) else $error("err");
    pkt_end_a: assert property (($fell(pcs_decode_en) && !rx_path_reset) |-> !$past(rx_pkt_active))
        else $error("cut");
    reset_off_a: assert property (rx_path_reset |-> rx_off) else $error("rst");
    no_rerun_a: assert property ($rose(pcs_decode_en) |-> !rx_path_reset) else $error("run");
    reset_hold_a: assert property ($rose(rx_path_reset) |-> reset_held) else $error("hold");
    fault_init_a: assert property (tx_local_fault |-> rx_off) else $error("init");
endmodule
bind lfrc_top lfrc_checker #(.LANES(LANES)) lfrc_checker_i (.*);

/* File: sim/lfrc_partner.sv */
// Purpose: link partner, random packets and lane header errors
// Assumes: lanes stay aligned
// Notes: packet flag random each cycle, so drains end quickly
`timescale 1ns/1ps
module lfrc_partner (
    input  wire logic  clk,
    output logic       rx_pkt_active = 1'b0,
    output logic       rx_lanes_aligned = 1'b1,
    output logic [39:0] lane_hdr_err = 40'h00_0000_0000
);
    int seed = 32'h0000_d263;
    always @(posedge clk) rx_pkt_active <= 1'($random(seed));
    always @(posedge clk) lane_hdr_err <= {8'($random(seed)), 32'($random(seed))};
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench of lfrc_top
// Assumes: ctrl at offset 0, four cycles to settle
// Notes: tx packet flag low in the code sweep, so tx enable changes show at once
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hwrite = 1'b0;
    logic        tx_pkt_active = 1'b0;
    logic        seg_valid_in = 1'b0;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        pcs_decode_en;
    logic        rx_path_reset;
    logic        user_segment_bus_valid;
    logic        stat_en;
    logic        tx_local_fault;
    logic        rx_pkt_active;
    logic        rx_lanes_aligned;
    logic        e_seg;
    logic [1:0]  htrans = 2'h0;
    logic [1:0]  tx_code_sel;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [39:0] lane_hdr_err;
    logic [39:0] framing_err;
    logic [39:0] e_err;
    logic [19:0] framing_err_valid;
    int          seed = 32'h0000_d263;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #10 clk = ~clk;
    always @(posedge clk) seg_valid_in <= 1'($random(seed));
    lfrc_partner lfrc_partner_i (.*);
    lfrc_top lfrc_top_i (.*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout));
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // forced codes by priority lfi, rfi, idle; a disabled tx sends idles
    function automatic logic [63:0] exp_code(input logic [3:0] c);
        if (c[1]) return 64'(lfrc_pkg::LFRC_TX_LFI);
        else if (c[2]) return 64'(lfrc_pkg::LFRC_TX_RFI);
        else if (c[3] || !c[0]) return 64'(lfrc_pkg::LFRC_TX_IDLE);
        return 64'(lfrc_pkg::LFRC_TX_DATA);
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        n_checks++;
        if (s !== e) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 5000) begin bad_count++; stop_test; end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("ctrl", 64'h0000_0016, r);
        chk("lf_init", 64'h0000_0001, tx_local_fault);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, 32'h0000_0000, 32'h0000_0010 | 32'(i));
            repeat (4) @(posedge clk);
            chk("code", exp_code(4'(i)), tx_code_sel);
        end
        bus(1'b1, 32'h0000_0000, 32'h0000_0018);
        repeat (4) @(posedge clk);
        chk("idle", 64'(lfrc_pkg::LFRC_TX_IDLE), tx_code_sel);
        bus(1'b1, 32'h0000_0000, 32'h0000_0015);
        repeat (4) @(posedge clk);
        chk("rfi", 64'(lfrc_pkg::LFRC_TX_RFI), tx_code_sel);
        bus(1'b1, 32'h0000_0000, 32'h0000_0013);
        repeat (4) @(posedge clk);
        chk("lfi", 64'(lfrc_pkg::LFRC_TX_LFI), tx_code_sel);
        chk("lf_run", 64'h0000_0000, tx_local_fault);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            e_err = lane_hdr_err;
            e_seg = seg_valid_in;
            @(posedge clk);
            chk("err", 64'(e_err), framing_err);
            chk("err_valid", 64'h000f_ffff, framing_err_valid);
            chk("seg", 64'(e_seg), user_segment_bus_valid);
            chk("stat", 64'h0000_0001, stat_en);
        end
        bus(1'b1, 32'h0000_000c, 32'h0000_0002);
        @(posedge clk);
        chk("irq_err", 64'h0000_0001, irq);
        bus(1'b1, 32'h0000_0000, 32'h0000_0011);
        repeat (4) @(posedge clk);
        chk("tx_data", 64'(lfrc_pkg::LFRC_TX_DATA), tx_code_sel);
        tx_pkt_active <= 1'b1;
        bus(1'b1, 32'h0000_0000, 32'h0000_0010);
        repeat (4) @(posedge clk);
        chk("tx_drain", 64'(lfrc_pkg::LFRC_TX_DATA), tx_code_sel);
        tx_pkt_active <= 1'b0;
        repeat (4) @(posedge clk);
        chk("tx_stop", 64'(lfrc_pkg::LFRC_TX_IDLE), tx_code_sel);
        bus(1'b1, 32'h0000_0000, 32'h0000_0030);
        @(posedge clk);
        chk("rx_reset", 64'h0000_0001, rx_path_reset);
        chk("decode_rs", 64'h0000_0000, pcs_decode_en);
        chk("lf_resync", 64'h0000_0001, tx_local_fault);
        repeat (30) @(posedge clk);
        chk("realign", 64'h0000_0001, pcs_decode_en);
        chk("reset_off", 64'h0000_0000, rx_path_reset);
        bus(1'b1, 32'h0000_0008, 32'h0000_0007);
        bus(1'b1, 32'h0000_000c, 32'h0000_0004);
        bus(1'b1, 32'h0000_0000, 32'h0000_0000);
        repeat (20) @(posedge clk);
        chk("decode", 64'h0000_0000, pcs_decode_en);
        chk("bus_off", 64'h0000_0000, user_segment_bus_valid);
        chk("stat_off", 64'h0000_0000, stat_en);
        chk("err_off", 64'h0000_0000, framing_err_valid);
        chk("irq_stop", 64'h0000_0001, irq);
        bus(1'b1, 32'h0000_0008, 32'h0000_0004);
        @(posedge clk);
        chk("irq_clr", 64'h0000_0000, irq);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk("irq_reg", 64'h0000_0000, 64'(r[2]));
        stop_test;
    end
endmodule
